// >>> rtl/psr_defines.svh
`ifndef PSR_DEFINES_SVH
`define PSR_DEFINES_SVH

// System clock period
`define PSR_MCLK_NS 8

// Reset pulse to the memory and recovery before first request
`define PSR_RST_PULSE_NS 200
`define PSR_RST_RECOVER_NS 400
`define PSR_RST_PULSE_CYC ((`PSR_RST_PULSE_NS + `PSR_MCLK_NS - 1) / `PSR_MCLK_NS)
`define PSR_RST_DONE_CYC (`PSR_RST_PULSE_CYC + \
  (`PSR_RST_RECOVER_NS + `PSR_MCLK_NS - 1) / `PSR_MCLK_NS)

// Chip select high time between transactions
`define PSR_CS_HIGH_NS 24
`define PSR_CS_HIGH_CYC ((`PSR_CS_HIGH_NS + `PSR_MCLK_NS - 1) / `PSR_MCLK_NS)

// Initial access latency in link clock cycles
`define PSR_LAT_CK 7

// Longest burst in words
`define PSR_MAX_WORDS 64

// Link clock edges in the command and address phase
`define PSR_CMD_EDGES 2
`define PSR_CA_EDGES 6

`endif

// >>> rtl/psr_pkg.sv
`default_nettype none

package psr_pkg;

  typedef enum logic [2:0] {
    PSR_IDLE  = 3'h0,
    PSR_SETUP = 3'h1,
    PSR_CA    = 3'h3,
    PSR_LAT   = 3'h2,
    PSR_DATA  = 3'h6,
    PSR_END   = 3'h7
  } psr_state_type;

endpackage : psr_pkg

`default_nettype wire

// >>> rtl/psr_sync.sv
`timescale 1ns/10ps
`default_nettype none

module psr_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule : psr_sync

`default_nettype wire

// >>> rtl/psr_pack.sv
`timescale 1ns/10ps
`default_nettype none

module psr_pack (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clear,
  input wire logic byte_stb,
  input wire logic [7:0] byte_in,
  output logic word_valid,
  output logic [15:0] word
);

  logic [7:0] hi_q;
  logic half_q;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      hi_q <= 8'h00;
      half_q <= 1'b0;
      word_valid <= 1'b0;
      word <= 16'h0000;
    end else begin
      word_valid <= 1'b0;
      if (clear) begin
        half_q <= 1'b0;
      end else if (byte_stb && !half_q) begin
        hi_q <= byte_in;
        half_q <= 1'b1;
      end else if (byte_stb) begin
        // First byte on the wire lands in the upper half
        word <= {hi_q, byte_in};
        word_valid <= 1'b1;
        half_q <= 1'b0;
      end
    end
  end

endmodule : psr_pack

`default_nettype wire

// >>> rtl/psr_host.sv
// Overview of operation
// - Chip select low frames one transaction
// - One byte per clock edge, two per cycle
// - Command opcode byte sent on both edges
// - Address and data phases are optional
// - Clock keeps toggling through read latency
// - Register writes carry no latency period
// - Array writes wait latency with clock running
// - All fields shifted most significant first
// - Highest address byte goes out first
// - Three cycles carry command and address
// - Host bounds burst length, accepts refresh latency
// - Each address names one 16-bit word
// - Host drives strobe as write mask on array writes only
// - Select falls before clock starts toggling
`timescale 1ns/10ps
`default_nettype none
`include "psr_defines.svh"

module psr_host #(
  parameter int LAT_CK = `PSR_LAT_CK,
  parameter int MAX_WORDS = `PSR_MAX_WORDS
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic req_reg,
  input wire logic req_has_addr,
  input wire logic [7:0] req_cmd,
  input wire logic [31:0] req_addr,
  input wire logic [9:0] req_len,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [15:0] wr_data,
  input wire logic [1:0] wr_mask,
  output logic rd_valid,
  output logic [15:0] rd_data,
  output logic busy,
  output logic mem_cs_n,
  output logic mem_ck,
  output logic mem_reset_n,
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out,
  output logic dq_oe,
  input wire logic rw_data_strobe_in,
  output logic rw_data_strobe_out,
  output logic rw_data_strobe_oe
);

  localparam logic [9:0] MAXW = 10'(MAX_WORDS);
  localparam logic [9:0] LAT1_EDGES = 10'(2 * LAT_CK);
  localparam logic [9:0] LAT2_EDGES = 10'(4 * LAT_CK);
  localparam logic [6:0] RST_PULSE = 7'(`PSR_RST_PULSE_CYC);
  localparam logic [6:0] RST_DONE = 7'(`PSR_RST_DONE_CYC);
  localparam logic [3:0] CSH = 4'(`PSR_CS_HIGH_CYC);
  localparam logic [9:0] CMD_EDGES = 10'(`PSR_CMD_EDGES);
  localparam logic [9:0] CA_EDGES = 10'(`PSR_CA_EDGES);
  localparam int LAT1_CYC = 4 * LAT_CK;
  localparam int LAT2_CYC = 8 * LAT_CK;

  psr_pkg::psr_state_type state_q;
  logic ph_q, ck_q, cs_n_q, rst_n_q, ready_q;
  logic [6:0] rst_cnt_q;
  logic [3:0] csh_q;
  logic [9:0] ecnt_q, lim_q, rcnt_q, len_q, len2;
  logic wr_q, reg_q, has_addr_q, rw_data_strobe_lat_q;
  logic [7:0] cmd_q, dq_q, lo_q;
  logic [31:0] adr_q;
  logic lo_m_q, rw_data_strobe_o_q, rw_data_strobe_oe_q, dq_oe_q;
  logic armed_q, rw_data_strobe_p_q;
  logic [7:0] dq_s;
  logic rw_data_strobe_s;
  logic at_lim, rd_phase, rd_fin, wr_take, stall, byte_stb, accept;

  function automatic logic [7:0] ca_byte(input logic [2:0] idx,
                                          input logic [7:0] cmd,
                                          input logic [31:0] adr);
    case (idx)
      3'h0, 3'h1: ca_byte = cmd;
      3'h2: ca_byte = adr[31:24];
      3'h3: ca_byte = adr[23:16];
      3'h4: ca_byte = adr[15:8];
      3'h5: ca_byte = adr[7:0];
      default: ca_byte = 8'h00;
    endcase
  endfunction : ca_byte

  // Pins come from the memory's timing, not ours
  psr_sync #(.W(8)) u_dq_sync (
    .mclk(mclk),
    .resetn(resetn),
    .d(dq_in),
    .q(dq_s)
  );

  psr_sync #(.W(1)) u_rw_data_strobe_sync (
    .mclk(mclk),
    .resetn(resetn),
    .d(rw_data_strobe_in),
    .q(rw_data_strobe_s)
  );

  assign len2 = {len_q[8:0], 1'b0};
  assign at_lim = (ecnt_q == lim_q);
  assign rd_phase = (state_q == psr_pkg::PSR_DATA) && !wr_q;
  assign rd_fin = (rcnt_q == len2);
  assign wr_take = (state_q == psr_pkg::PSR_DATA) && wr_q && ph_q &&
                   !ecnt_q[0] && !at_lim;
  assign wr_ready = wr_take && wr_valid;
  // No word ready: freeze the clock rather than send stale data
  assign stall = wr_take && !wr_valid;
  assign accept = (state_q == psr_pkg::PSR_IDLE) && ready_q && req_valid;
  assign req_ready = (state_q == psr_pkg::PSR_IDLE) && ready_q;
  assign busy = (state_q != psr_pkg::PSR_IDLE);

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rst_cnt_q <= 7'h00;
      rst_n_q <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      if (rst_cnt_q != RST_DONE) begin
        rst_cnt_q <= rst_cnt_q + 7'h01;
      end
      rst_n_q <= (rst_cnt_q >= RST_PULSE);
      ready_q <= (rst_cnt_q == RST_DONE);
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wr_q <= 1'b0;
      reg_q <= 1'b0;
      has_addr_q <= 1'b0;
      cmd_q <= 8'h00;
      adr_q <= 32'h0000_0000;
      len_q <= 10'h000;
    end else if (accept) begin
      wr_q <= req_write;
      reg_q <= req_reg;
      has_addr_q <= req_has_addr;
      cmd_q <= req_cmd;
      adr_q <= req_addr;
      len_q <= (req_len > MAXW) ? MAXW : req_len;
    end
  end

  // Sequencer: ph_q high is the load half, low is the clock edge half
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_q <= psr_pkg::PSR_IDLE;
      ph_q <= 1'b1;
      ck_q <= 1'b0;
      cs_n_q <= 1'b1;
      ecnt_q <= 10'h000;
      lim_q <= 10'h000;
      csh_q <= 4'h0;
      rw_data_strobe_lat_q <= 1'b0;
    end else begin
      case (state_q)
        psr_pkg::PSR_IDLE: begin
          if (accept) begin
            cs_n_q <= 1'b0;
            state_q <= psr_pkg::PSR_SETUP;
          end
        end
        psr_pkg::PSR_SETUP: begin
          state_q <= psr_pkg::PSR_CA;
          ph_q <= 1'b1;
          ecnt_q <= 10'h000;
          lim_q <= has_addr_q ? CA_EDGES : CMD_EDGES;
        end
        psr_pkg::PSR_CA, psr_pkg::PSR_LAT, psr_pkg::PSR_DATA: begin
          if (!ph_q) begin
            ck_q <= ~ck_q;
            ecnt_q <= ecnt_q + 10'h001;
            ph_q <= 1'b1;
          end else if (rd_phase) begin
            // clock runs until all bytes are in
            if (rd_fin && !ecnt_q[0]) begin
              state_q <= psr_pkg::PSR_END;
              cs_n_q <= 1'b1;
              csh_q <= 4'h0;
            end else begin
              ph_q <= 1'b0;
            end
          end else if (at_lim) begin
            ecnt_q <= 10'h000;
            lim_q <= len2;
            if (state_q == psr_pkg::PSR_CA) begin
              rw_data_strobe_lat_q <= rw_data_strobe_s;
              if (!has_addr_q || len_q == 10'h000) begin
                state_q <= psr_pkg::PSR_END;
                cs_n_q <= 1'b1;
                csh_q <= 4'h0;
              end else if (!wr_q || reg_q) begin
                state_q <= psr_pkg::PSR_DATA;
              end else begin
                state_q <= psr_pkg::PSR_LAT;
                lim_q <= rw_data_strobe_s ? LAT2_EDGES : LAT1_EDGES;
              end
            end else if (state_q == psr_pkg::PSR_LAT) begin
              state_q <= psr_pkg::PSR_DATA;
            end else begin
              state_q <= psr_pkg::PSR_END;
              cs_n_q <= 1'b1;
              csh_q <= 4'h0;
            end
          end else if (!stall) begin
            ph_q <= 1'b0;
          end
        end
        psr_pkg::PSR_END: begin
          if (csh_q == CSH) begin
            state_q <= psr_pkg::PSR_IDLE;
          end else begin
            csh_q <= csh_q + 4'h1;
          end
        end
        default: state_q <= psr_pkg::PSR_IDLE;
      endcase
    end
  end

  // Bus drivers
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      dq_q <= 8'h00;
      dq_oe_q <= 1'b0;
      lo_q <= 8'h00;
      lo_m_q <= 1'b0;
      rw_data_strobe_o_q <= 1'b0;
      rw_data_strobe_oe_q <= 1'b0;
    end else if (state_q == psr_pkg::PSR_CA && ph_q) begin
      dq_q <= ca_byte(ecnt_q[2:0], cmd_q, adr_q);
      dq_oe_q <= !at_lim;
    end else if (wr_ready) begin
      // first byte is the upper half
      dq_q <= wr_data[15:8];
      lo_q <= wr_data[7:0];
      lo_m_q <= wr_mask[0];
      dq_oe_q <= 1'b1;
      // mask on strobe for array writes
      rw_data_strobe_o_q <= wr_mask[1];
      rw_data_strobe_oe_q <= !reg_q;
    end else if (state_q == psr_pkg::PSR_DATA && wr_q && ph_q && ecnt_q[0]) begin
      dq_q <= lo_q;
      rw_data_strobe_o_q <= lo_m_q;
    end else if (state_q == psr_pkg::PSR_END || state_q == psr_pkg::PSR_LAT || at_lim) begin
      dq_oe_q <= 1'b0;
      rw_data_strobe_oe_q <= 1'b0;
    end
  end

  assign byte_stb = armed_q && (rw_data_strobe_s ^ rw_data_strobe_p_q) && !rd_fin;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      armed_q <= 1'b0;
      rw_data_strobe_p_q <= 1'b0;
      rcnt_q <= 10'h000;
    end else begin
      rw_data_strobe_p_q <= rw_data_strobe_s;
      // Refresh flag may still be high; wait for preamble low
      armed_q <= rd_phase && (armed_q || !rw_data_strobe_s);
      if (state_q == psr_pkg::PSR_SETUP) begin
        rcnt_q <= 10'h000;
      end else if (byte_stb) begin
        rcnt_q <= rcnt_q + 10'h001;
      end
    end
  end

  psr_pack u_pack (
    .mclk(mclk),
    .resetn(resetn),
    .clear(state_q == psr_pkg::PSR_SETUP),
    .byte_stb(byte_stb),
    .byte_in(dq_s),
    .word_valid(rd_valid),
    .word(rd_data)
  );

  assign mem_cs_n = cs_n_q;
  assign mem_ck = ck_q;
  assign mem_reset_n = rst_n_q;
  assign dq_out = dq_q;
  assign dq_oe = dq_oe_q;
  assign rw_data_strobe_out = rw_data_strobe_o_q;
  assign rw_data_strobe_oe = rw_data_strobe_oe_q;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  ck_idle_cs_a: assert property (mem_cs_n |-> !mem_ck)
    else $error("clock high outside a transaction");

  cs_setup_a: assert property ($fell(mem_cs_n) |-> !mem_ck ##1 !mem_ck ##1 !mem_ck)
    else $error("clock moved too soon after select");

  cmd_twice_a: assert property (
    (state_q == psr_pkg::PSR_CA && !ph_q && ecnt_q == 10'h000)
    |-> (dq_out == cmd_q) ##2 (dq_out == cmd_q && ecnt_q == 10'h001))
    else $error("opcode not repeated on both edges");

  ca_len_a: assert property (
    (state_q == psr_pkg::PSR_SETUP && has_addr_q)
    |-> ##13 (state_q == psr_pkg::PSR_CA) ##1 (state_q != psr_pkg::PSR_CA))
    else $error("command address phase length wrong");

  lat_double_a: assert property (
    ($rose(state_q == psr_pkg::PSR_LAT) && rw_data_strobe_lat_q)
    |-> ##LAT2_CYC (state_q == psr_pkg::PSR_LAT) ##1 (state_q != psr_pkg::PSR_LAT))
    else $error("refresh latency not doubled");

  lat_single_a: assert property (
    ($rose(state_q == psr_pkg::PSR_LAT) && !rw_data_strobe_lat_q)
    |-> ##LAT1_CYC (state_q == psr_pkg::PSR_LAT) ##1 (state_q != psr_pkg::PSR_LAT))
    else $error("single latency length wrong");

  lat_clock_a: assert property (
    (state_q == psr_pkg::PSR_LAT && !ph_q) |=> $changed(mem_ck))
    else $error("clock stopped during latency");

  reg_nolat_a: assert property (
    ($fell(state_q == psr_pkg::PSR_CA) && wr_q && reg_q && has_addr_q && len_q != 10'h000)
    |-> (state_q == psr_pkg::PSR_DATA))
    else $error("register write entered latency");

  mask_oe_a: assert property (
    rw_data_strobe_oe |-> (state_q == psr_pkg::PSR_DATA && wr_q && !reg_q))
    else $error("strobe driven outside write data");

  msb_first_a: assert property (
    wr_ready |=> (dq_out == $past(wr_data[15:8]))
    ##2 (dq_out == $past(wr_data[7:0], 3)))
    else $error("write byte order wrong");

  burst_cap_a: assert property (accept |=> (len_q <= MAXW))
    else $error("burst longer than allowed");

  read_c: cover property (rd_valid && rd_fin);
  write2x_c: cover property ($rose(state_q == psr_pkg::PSR_LAT) && rw_data_strobe_lat_q);
  cmd_only_c: cover property ($fell(state_q == psr_pkg::PSR_CA) && !has_addr_q);

endmodule : psr_host

`default_nettype wire

// >>> bench/psr_dev.sv
`timescale 1ns/10ps
`default_nettype none

module psr_dev #(
  parameter int LAT = 2
) (
  input wire logic cs_n,
  input wire logic ck,
  input wire logic reset_n,
  input wire logic refresh,
  input wire logic [7:0] hdq,
  input wire logic hrwds,
  output logic [7:0] dq,
  output logic rw_data_strobe,
  output int edges,
  output int txns,
  output int ck_bad,
  output logic [7:0] cmd0,
  output logic [7:0] cmd1
);
  logic [15:0] mem [logic [32:0]];
  logic [31:0] adr;
  logic [32:0] k;
  logic [15:0] w;
  logic rd, rg, rf;
  int lat, b;

  initial begin
    dq = 8'h5a;
    rw_data_strobe = 1'b0;
    edges = 0;
    txns = 0;
    ck_bad = 0;
  end

  // frame opens, clock must be idle
  always @(negedge cs_n) begin
    if (reset_n) begin
      txns = txns + 1;
      if (ck) ck_bad = ck_bad + 1;
      edges = 0;
      rf = refresh;
      rw_data_strobe = rf;
    end
  end

  // released lines show inverse, not last value
  always @(posedge cs_n or negedge reset_n) begin
    dq = ~dq;
    rw_data_strobe = ~rw_data_strobe;
  end

  always @(posedge ck or negedge ck) begin
    if (!cs_n && reset_n) begin
      if (edges == 0) cmd0 = hdq;
      if (edges == 1) begin
        cmd1 = hdq;
        rd = hdq[7];
        rg = hdq[6];
      end
      if (edges >= 2 && edges <= 5) adr = {adr[23:0], hdq};
      // latency in edges, doubled on refresh
      if (edges == 5) lat = (rg && !rd) ? 0 : 2 * LAT * (rf ? 2 : 1);
      if (edges == 6) rw_data_strobe = rd ? 1'b0 : ~rw_data_strobe;
      b = edges - 6 - lat;
      if (edges > 5 && b >= 0) begin
        k = {rg, adr + 32'(b / 2)};
        w = mem.exists(k) ? mem[k] : 16'h0000;
        if (rd) begin
          // high byte first, strobe in phase
          dq = b[0] ? w[7:0] : w[15:8];
          rw_data_strobe = ~b[0];
        end else begin
          // masked bytes stay as they were
          if (!b[0] && (rg || !hrwds)) w[15:8] = hdq;
          if (b[0] && (rg || !hrwds)) w[7:0] = hdq;
          mem[k] = w;
        end
      end
      edges = edges + 1;
    end
  end
endmodule : psr_dev

`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  localparam int LAT = 2;
  localparam logic [7:0] OP_WR = 8'h2a;
  localparam logic [7:0] OP_RD = 8'haa;
  localparam logic [7:0] OP_RGW = 8'h6a;
  localparam logic [7:0] OP_RGR = 8'hea;
  localparam logic [7:0] OP_NOP = 8'h1e;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic req_reg = 1'b0;
  logic req_has_addr = 1'b0;
  logic [7:0] req_cmd = 8'h00;
  logic [31:0] req_addr = 32'h0000_0000;
  logic [9:0] req_len = 10'h000;
  logic wr_valid = 1'b0;
  logic [15:0] wr_data = 16'h0000;
  logic [1:0] wr_mask = 2'h0;
  logic refresh = 1'b0;
  logic req_ready, wr_ready, rd_valid, busy, mem_cs_n, mem_ck, mem_reset_n;
  logic dq_oe, rw_data_strobe_out, rw_data_strobe_oe, rw_data_strobe_in, m_rw_data_strobe;
  logic [15:0] rd_data;
  logic [7:0] dq_out, dq_in, m_dq, cmd0, cmd1;
  int edges, txns, ck_bad;
  int num_errors = 0;
  int checks = 0;
  logic [31:0] rnd = 32'h3a90;
  logic [15:0] ref_mem [logic [32:0]];
  logic [15:0] wq [$];
  logic [1:0] mq [$];

  always #4 mclk = ~mclk;
  assign dq_in = dq_oe ? dq_out : m_dq;
  assign rw_data_strobe_in = rw_data_strobe_oe ? rw_data_strobe_out : m_rw_data_strobe;

  psr_host #(.LAT_CK(LAT), .MAX_WORDS(64)) dut (.mclk(mclk), .resetn(resetn),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write), .req_reg(req_reg),
    .req_has_addr(req_has_addr), .req_cmd(req_cmd), .req_addr(req_addr), .req_len(req_len),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .wr_mask(wr_mask),
    .rd_valid(rd_valid), .rd_data(rd_data), .busy(busy), .mem_cs_n(mem_cs_n),
    .mem_ck(mem_ck), .mem_reset_n(mem_reset_n), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe(dq_oe), .rw_data_strobe_in(rw_data_strobe_in), .rw_data_strobe_out(rw_data_strobe_out), .rw_data_strobe_oe(rw_data_strobe_oe));

  psr_dev #(.LAT(LAT)) dev (.cs_n(mem_cs_n), .ck(mem_ck), .reset_n(mem_reset_n),
    .refresh(refresh), .hdq(dq_in), .hrwds(rw_data_strobe_in), .dq(m_dq), .rw_data_strobe(m_rw_data_strobe),
    .edges(edges), .txns(txns), .ck_bad(ck_bad), .cmd0(cmd0), .cmd1(cmd1));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic give_verdict;
    $display("checks=%0d errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict

  task automatic hang;
    chk(32'h0000_0000, 32'h0000_0001);
    give_verdict();
  endtask : hang

  task automatic fill(input int n, input logic m);
    wq.delete();
    mq.delete();
    for (int i = 0; i < n; i++) begin
      rnd = lfsr(rnd);
      wq.push_back(rnd[15:0]);
      mq.push_back(m ? rnd[17:16] : 2'h0);
    end
  endtask : fill

  // Request held until the edge that samples ready
  task automatic issue(input logic [7:0] op, input logic ha, input logic [31:0] a, input int n);
    int i;
    @(negedge mclk);
    req_valid = 1'b1;
    req_write = !op[7];
    req_reg = op[6];
    req_has_addr = ha;
    req_cmd = op;
    req_addr = a;
    req_len = 10'(n);
    wr_valid = !op[7] && n > 0;
    wr_data = wq[0];
    wr_mask = mq[0];
    for (i = 0; i < 200 && !req_ready; i++) @(negedge mclk);
    if (!req_ready) hang();
    @(negedge mclk);
    req_valid = 1'b0;
  endtask : issue

  task automatic xfer(input logic [7:0] op, input logic ha, input logic [31:0] a, input int n);
    logic [32:0] k;
    logic [15:0] e;
    logic tk;
    int i, got, gap;
    got = 0;
    gap = 0;
    tk = 1'b0;
    for (i = 0; i < n && !op[7]; i++) begin
      k = {op[6], a + 32'(i)};
      e = ref_mem.exists(k) ? ref_mem[k] : 16'h0000;
      if (op[6] || !mq[i][1]) e[15:8] = wq[i][15:8];
      if (op[6] || !mq[i][0]) e[7:0] = wq[i][7:0];
      ref_mem[k] = e;
    end
    issue(op, ha, a, n);
    for (i = 0; i < 4000 && got < n; i++) begin
      @(negedge mclk);
      if (!op[7] && tk) begin
        got++;
        // Random gaps make the host freeze its link clock
        rnd = lfsr(rnd);
        gap = int'(rnd[2:0]);
        wr_valid = 1'b0;
        if (got < n) begin
          wr_data = wq[got];
          wr_mask = mq[got];
        end
      end else if (gap > 0) begin
        gap--;
      end else if (!op[7] && got < n) begin
        wr_valid = 1'b1;
      end
      // Ready is combinational on valid, so let it settle first
      #1 tk = wr_ready;
      if (op[7] && rd_valid) begin
        k = {op[6], a + 32'(got)};
        e = ref_mem.exists(k) ? ref_mem[k] : 16'h0000;
        chk(rd_data, e);
        got++;
      end
    end
    for (i = 0; i < 400 && busy; i++) @(negedge mclk);
    if (got < n || busy) hang();
  endtask : xfer

  initial begin
    repeat (5) @(negedge mclk);
    chk({mem_cs_n, mem_reset_n, req_ready, dq_oe, rw_data_strobe_oe}, 32'h0000_0010);
    resetn = 1'b1;
    fill(4, 1'b1);
    xfer(OP_WR, 1'b1, 32'h0000_0100, 4);
    chk(edges, 6 + 2 * LAT + 8);
    $display("test masked write done");
    refresh = 1'b1;
    fill(3, 1'b0);
    xfer(OP_WR, 1'b1, 32'h0000_0203, 3);
    chk(edges, 6 + 4 * LAT + 6);
    refresh = 1'b0;
    $display("test refresh write done");
    fill(1, 1'b0);
    xfer(OP_RGW, 1'b1, 32'h0000_0002, 1);
    chk(edges, 6 + 2);
    xfer(OP_RGR, 1'b1, 32'h0000_0002, 1);
    $display("test register done");
    xfer(OP_RD, 1'b1, 32'h0000_0100, 4);
    refresh = 1'b1;
    xfer(OP_RD, 1'b1, 32'h0000_0203, 3);
    refresh = 1'b0;
    $display("test read done");
    xfer(OP_NOP, 1'b0, 32'h0000_0000, 0);
    chk(edges, 2);
    chk({cmd0, cmd1}, {OP_NOP, OP_NOP});
    $display("test command only done");
    fill(2, 1'b0);
    issue(OP_WR, 1'b1, 32'h0000_0300, 2);
    repeat (12) @(negedge mclk);
    chk(mem_cs_n, 1'b0);
    resetn = 1'b0;
    wr_valid = 1'b0;
    repeat (2) @(negedge mclk);
    chk({mem_cs_n, mem_reset_n, dq_oe, rw_data_strobe_oe}, 32'h0000_0008);
    resetn = 1'b1;
    xfer(OP_RD, 1'b1, 32'h0000_0100, 4);
    $display("test reset in frame done");
    chk(txns, 9);
    chk(ck_bad, 0);
    give_verdict();
  end
endmodule : tb_top

`default_nettype wire
